// ===== design/interrupt_priority_regs.sv
// priority configuration registers and level arbitration for five interrupt sources
// assumes: sfr bus strobes are one-cycle pulses synchronous to mclk_in;
// the core tells which levels are in service through active_levels_in
`include "prio_regs_cfg.svh"

// Functional notes
// - high register at B7h, five source bits
// - low register, same bit assignment
// - level is high bit over low bit
// - low register clears, allows bit operations
// - high register clears, byte access only
// - four levels, three most urgent
// - preempt only by strictly higher level
// - higher level wins, ties by polling
module interrupt_priority_regs #(
    parameter int NUM_SRC = 5
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // special function register bus
    input wire prio_regs_pkg::sfr_req_t sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    // request side
    input wire logic [NUM_SRC-1:0] irq_req_in,
    input wire logic [3:0] active_levels_in,
    // results
    output prio_regs_pkg::prio_levels_t levels_out,
    output prio_regs_pkg::grant_t grant_out
);
    import prio_regs_pkg::*;

    // byte addresses held as sized values so their bit base can be sliced
    localparam logic [7:0] HIGH_ADDR = `PRIO_HIGH_ADDR; // high register byte address
    localparam logic [7:0] LOW_ADDR = `PRIO_LOW_ADDR;   // low register byte address
    localparam logic [2:0] TOP_BIT = 3'(`PRIO_SERIAL_POS); // last used bit index

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] hi; // high register, used bits only
        logic [4:0] lo; // low register, used bits only
    } state_t;

    state_t cur;      // registered state
    state_t next_cur; // next state
    prio_levels_t lvl; // level per source
    grant_t gnt;       // arbitration result
    logic [1:0] cur_lvl; // highest level in service
    logic busy;          // something in service

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // bit address of the low register is its byte address plus bit index
    always_comb begin
        next_cur = cur;
        if (sfr_req_in.wr && sfr_req_in.addr == `PRIO_HIGH_ADDR) begin
            // reserved bits are dropped; software keeps them zero
            next_cur.hi = sfr_req_in.wdata[4:0];
        end
        if (sfr_req_in.wr && sfr_req_in.addr == `PRIO_LOW_ADDR) begin
            next_cur.lo = sfr_req_in.wdata[4:0];
        end
        // bit addresses B8h..BFh map onto the low register, one per bit
        if (sfr_req_in.bit_wr && sfr_req_in.addr[7:3] == LOW_ADDR[7:3]) begin
            // single-bit set or clear, low register only
            // bit addresses above the serial bit are reserved and dropped
            if (sfr_req_in.addr[2:0] <= TOP_BIT) begin
                next_cur.lo[sfr_req_in.addr[2:0]] = sfr_req_in.bit_val;
            end
        end
        // bit operations at B0h..B7h never reach the high register
    end

    // registers clear on reset
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cur.hi <= `PRIO_HIGH_RESET;
            cur.lo <= `PRIO_LOW_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // a byte write must land whole on the next edge
    a_hi_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sfr_req_in.wr && sfr_req_in.addr == HIGH_ADDR
        |=> cur.hi == $past(sfr_req_in.wdata[4:0]))
        else $error("high register write lost");

    // a bit write in the same cycle wins on the low register, so it is left out here
    a_lo_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sfr_req_in.wr && !sfr_req_in.bit_wr && sfr_req_in.addr == LOW_ADDR
        |=> cur.lo == $past(sfr_req_in.wdata[4:0]))
        else $error("low register write lost");

    // a single-bit write to a used bit must land on that bit
    a_lo_bit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sfr_req_in.bit_wr && sfr_req_in.addr[7:3] == LOW_ADDR[7:3]
        && sfr_req_in.addr[2:0] <= TOP_BIT
        |=> cur.lo[$past(sfr_req_in.addr[2:0])] == $past(sfr_req_in.bit_val))
        else $error("low register bit write lost");

    // reserved bit positions of the low register must not disturb it
    a_lo_resv: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sfr_req_in.bit_wr && !sfr_req_in.wr && sfr_req_in.addr[7:3] == LOW_ADDR[7:3]
        && sfr_req_in.addr[2:0] > TOP_BIT |=> $stable(cur.lo))
        else $error("reserved bit write changed low register");

    // bit operations never reach the byte-only high register
    a_hi_nobit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sfr_req_in.bit_wr && !sfr_req_in.wr |=> $stable(cur.hi))
        else $error("bit write changed high register");

    // the edge after any reset edge shows cleared registers
    a_lo_reset: assert property (@(posedge mclk_in)
        !rst_n_in |=> cur.lo == `PRIO_LOW_RESET)
        else $error("low register not cleared");

    a_hi_reset: assert property (@(posedge mclk_in)
        !rst_n_in |=> cur.hi == `PRIO_HIGH_RESET)
        else $error("high register not cleared");

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // reserved bits read as zero
    always_comb begin
        sfr_rdata_out = 8'h00;
        sfr_hit_out = 1'b0;
        if (sfr_req_in.addr == `PRIO_HIGH_ADDR) begin
            sfr_rdata_out = {3'h0, cur.hi};
            sfr_hit_out = 1'b1;
        end else if (sfr_req_in.addr == `PRIO_LOW_ADDR) begin
            sfr_rdata_out = {3'h0, cur.lo};
            sfr_hit_out = 1'b1;
        end
    end

    // reserved bits always read back clear, whatever the address
    a_resv_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sfr_rdata_out[7:5] == 3'h0)
        else $error("reserved bits nonzero");

    // ----------------------------------------
    // levels and arbitration
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_lvl
            assign lvl.level[g] = {cur.hi[g], cur.lo[g]};
        end
    endgenerate
    assign levels_out = lvl;

    // high bit is the upper bit of the level, low bit the lower one
    a_level_form: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        levels_out.level[4] == {cur.hi[4], cur.lo[4]})
        else $error("serial level misformed");

    // both bits set give the most urgent of the four levels
    a_four_lvl: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        cur.hi[0] && cur.lo[0] |-> levels_out.level[0] == 2'h3)
        else $error("level three not formed");

    // highest level in service
    always_comb begin
        busy = |active_levels_in;
        cur_lvl = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (active_levels_in[i]) cur_lvl = 2'(i);
        end
    end

    // scan from last polled to first so the first polled source wins ties
    always_comb begin
        gnt = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (irq_req_in[i] && (!gnt.valid || lvl.level[i] >= gnt.level)) begin
                gnt.valid = 1'b1;
                gnt.src = 3'(i);
                gnt.level = lvl.level[i];
            end
        end
        // only a strictly higher level may preempt
        if (busy && gnt.level <= cur_lvl) gnt.valid = 1'b0;
    end
    assign grant_out = gnt;

    // a routine in service is only cut short by a strictly higher level
    a_preempt: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_out.valid && busy |-> grant_out.level > cur_lvl)
        else $error("preempt at equal or lower level");

    // nothing interrupts a routine at the most urgent level
    a_top_busy: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        busy && cur_lvl == 2'h3 |-> !grant_out.valid)
        else $error("top level routine preempted");

    // a pending request of source 0 at a higher level is never passed over
    a_top_wins: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_out.valid |-> !(irq_req_in[0] && levels_out.level[0] > grant_out.level))
        else $error("lower level served first");

    // the first polled source wins a tie at its level
    a_tie_poll: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_out.valid && grant_out.src != 3'h0
        |-> !(irq_req_in[0] && levels_out.level[0] == grant_out.level))
        else $error("tie not resolved by polling order");

    // only a pending source may be granted
    a_grant_req: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_out.valid |-> irq_req_in[grant_out.src])
        else $error("grant to idle source");

    // the granted level is the one programmed for that source
    a_grant_lvl: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_out.valid |-> grant_out.level == levels_out.level[grant_out.src])
        else $error("grant level differs from source level");

endmodule // interrupt_priority_regs

// ===== pkg/prio_regs_cfg.svh
// constants of the interrupt priority register block
// assumes: included by the design and the bench, no other definitions
`ifndef PRIO_REGS_CFG_SVH
`define PRIO_REGS_CFG_SVH

// ----------------------------------------
// special function addresses
// ----------------------------------------
`define PRIO_HIGH_ADDR 8'hB7
`define PRIO_LOW_ADDR 8'hB8

// ----------------------------------------
// field positions, common to both registers
// ----------------------------------------
`define PRIO_EXT0_POS 0
`define PRIO_TMR0_POS 1
`define PRIO_EXT1_POS 2
`define PRIO_TMR1_POS 3
`define PRIO_SERIAL_POS 4
`define PRIO_USED_MASK 8'h1F

// ----------------------------------------
// reset values
// ----------------------------------------
`define PRIO_HIGH_RESET 5'h00
`define PRIO_LOW_RESET 5'h00

`endif

// ===== pkg/prio_regs_pkg.sv
// types of the interrupt priority register block
// assumes: compiled before the design file
package prio_regs_pkg;

    // ----------------------------------------
    // special function register bus request
    // ----------------------------------------
    typedef struct packed {
        logic wr;          // whole-byte write strobe
        logic bit_wr;      // single-bit write strobe
        logic [7:0] addr;  // byte address, or bit address for bit_wr
        logic [7:0] wdata; // byte data
        logic bit_val;     // value for a single-bit write
    } sfr_req_t;

    // ----------------------------------------
    // per-source levels and arbitration result
    // ----------------------------------------
    typedef struct packed {
        logic [4:0][1:0] level; // two-bit level per source
    } prio_levels_t;

    typedef struct packed {
        logic valid;       // some request may be taken now
        logic [2:0] src;   // source chosen
        logic [1:0] level; // level of that source
    } grant_t;

    typedef enum logic [0:0] {
        ST_RUN
    } dummy_state_t;

endpackage

// ===== test/interrupt_priority_regs_tb.sv
// self-checking bench: random register traffic and requests against an integer model
// assumes: design and cpu model compiled before, inputs driven at falling edges
`include "prio_regs_cfg.svh"
module interrupt_priority_regs_tb;
    import prio_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, rst_n_in;
    sfr_req_t req;
    logic [7:0] rdata;
    logic hit;
    logic [4:0] irq;
    logic [3:0] act;
    prio_levels_t lv;
    grant_t gr;
    int err_total, num_checks, seed, hi, lo, d, b, top, best, bl, l;
    interrupt_priority_regs dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sfr_req_in(req),
        .sfr_rdata_out(rdata), .sfr_hit_out(hit), .irq_req_in(irq), .active_levels_in(act),
        .levels_out(lv), .grant_out(gr));
    sfr_cpu_model cpu (.mclk_in(mclk_in), .req_out(req));
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // readback, level per source and arbitration against the model
    task automatic chk_all();
        cpu.rd(`PRIO_HIGH_ADDR);
        #1 check(rdata, 8'(hi));
        check({7'h00, hit}, 8'h01);
        cpu.rd(`PRIO_LOW_ADDR);
        #1 check(rdata, 8'(lo));
        cpu.rd(8'hA8);
        #1 check({hit, rdata[6:0]}, 8'h00);
        top = -1;
        for (b = 0; b < 4; b++) if (act[b]) top = b;
        best = -1;
        bl = 0;
        for (b = 0; b < 5; b++) begin
            l = 2 * hi[b] + lo[b];
            check({6'h00, lv.level[b]}, 8'(l));
            if (irq[b] && l > top && (best < 0 || l > bl)) begin
                best = b;
                bl = l;
            end
        end
        check({7'h00, gr.valid}, 8'(best >= 0));
        if (best >= 0) check({3'h0, gr.src, gr.level}, 8'(best * 4 + bl));
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
    initial begin
        seed = 40434;
        err_total = 0;
        num_checks = 0;
        hi = 0;
        lo = 0;
        rst_n_in = 1'b0;
        irq = '0;
        act = '0;
        repeat (10) @(negedge mclk_in);
        rst_n_in = 1'b1;
        chk_all();
        repeat (200) begin
            @(negedge mclk_in);
            d = $random(seed);
            b = d[12:10];
            case (d[9:8])
                2'd0: begin
                    cpu.wr_byte(`PRIO_HIGH_ADDR, d[7:0]);
                    hi = d & 'h1F;
                end
                2'd1: begin
                    if (d[25]) begin
                        // same-cycle byte and bit write: the bit write wins on bit 0
                        cpu.wr_both(`PRIO_LOW_ADDR, d[7:0], d[13]);
                        lo = (d & 'h1E) | d[13];
                    end else begin
                        cpu.wr_byte(`PRIO_LOW_ADDR, d[7:0]);
                        lo = d & 'h1F;
                    end
                end
                2'd2: begin
                    // bits 7..5 of the low register must stay clear
                    cpu.wr_bit(8'(`PRIO_LOW_ADDR + b), d[13] && b < 5);
                    if (b < 5) lo[b] = d[13];
                end
                default: cpu.wr_bit(8'(8'hB0 + b), d[13]); // high register has no bit access
            endcase
            irq = d[20:16];
            act = d[24:21];
            chk_all();
        end
        // second reset after the random run: both registers clear again
        @(negedge mclk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        rst_n_in = 1'b1;
        hi = 0;
        lo = 0;
        chk_all();
        print_verdict();
    end
endmodule // interrupt_priority_regs_tb

// ===== test/sfr_cpu_model.sv
// cpu-side software model: byte writes, bit writes and address set-up for reads
// assumes: called just after a falling edge of mclk_in, one access at a time
module sfr_cpu_model
    import prio_regs_pkg::*;
(
    // clock
    input wire logic mclk_in,
    // register bus toward the block
    output sfr_req_t req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_out = '0;
    // one-cycle byte write; software never sets reserved bits
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        req_out = '{wr: 1'b1, bit_wr: 1'b0, addr: a, wdata: d & 8'h1F, bit_val: 1'b0};
        @(negedge mclk_in);
        req_out.wr = 1'b0;
        req_out.wdata = ~req_out.wdata; // released data no longer shows the last value
    endtask
    // one-cycle single-bit write at a bit address
    task automatic wr_bit(input logic [7:0] a, input logic v);
        req_out = '{wr: 1'b0, bit_wr: 1'b1, addr: a, wdata: 8'hA5, bit_val: v};
        @(negedge mclk_in);
        req_out.bit_wr = 1'b0;
        req_out.bit_val = ~v;
    endtask
    // byte write and bit write in one cycle; a bit address of the low byte means bit 0
    task automatic wr_both(input logic [7:0] a, input logic [7:0] d, input logic v);
        req_out = '{wr: 1'b1, bit_wr: 1'b1, addr: a, wdata: d & 8'h1F, bit_val: v};
        @(negedge mclk_in);
        req_out.wr = 1'b0;
        req_out.bit_wr = 1'b0;
    endtask
    // reads are combinational: only the address is presented
    task automatic rd(input logic [7:0] a);
        req_out.addr = a;
    endtask
endmodule // sfr_cpu_model
